// ### design/acr_mode_regs.sv
/*
 Rate, filter and conversion-control registers with the start sequencer.
 Assumes a one-cycle register port on clock_in and a conversion engine
 on the same clock that pulses conv_done_in when a conversion ends.
*/
`timescale 1ns/1ps
`include "acr_defines.svh"
`default_nettype none
module acr_mode_regs
   import acr_pkg::*;
#(
   parameter int DELAY_TICK_CYCLES = `ACR_US_CYCLES
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   // conversion control
   input wire logic run_in,
   input wire logic ext_clk_in,
   input wire logic conv_done_in,
   // settings and status toward the engine
   output logic conv_start_out,
   output logic conv_busy_out,
   output logic delay_busy_out,
   output logic [4:0] act_rate_code_out,
   output logic [18:0] act_rate_dsps_out,
   output logic [2:0] act_filter_out,
   output logic act_mode_out
);

   logic [7:0] rate_filter_ff;
   logic [7:0] conv_ctrl_ff;
   logic [7:0] rsv_byte_ff;
   logic [7:0] rd_data_ff;
   logic run_d_ff;
   acr_state_t state_ff;
   acr_state_t nxt_state;
   logic [4:0] act_rate_ff;
   logic [2:0] act_filter_ff;
   logic act_mode_ff;
   logic [14:0] act_delay_ff;
   logic [14:0] nxt_delay;
   logic [15:0] tick_div_ff;
   logic [14:0] tick_cnt_ff;
   logic tick;
   logic start_req;
   logic conv_start_ff;

   // rate code to output rate
   function automatic logic [18:0] rate_of(input logic [4:0] code);
      case (code)
         5'h00: rate_of = `ACR_RATE_00;
         5'h01: rate_of = `ACR_RATE_01;
         5'h02: rate_of = `ACR_RATE_02;
         5'h03: rate_of = `ACR_RATE_03;
         5'h04: rate_of = `ACR_RATE_04;
         5'h05: rate_of = `ACR_RATE_05;
         5'h06: rate_of = `ACR_RATE_06;
         5'h07: rate_of = `ACR_RATE_07;
         5'h08: rate_of = `ACR_RATE_08;
         5'h09: rate_of = `ACR_RATE_09;
         5'h0a: rate_of = `ACR_RATE_0A;
         5'h0b: rate_of = `ACR_RATE_0B;
         5'h0c: rate_of = `ACR_RATE_0C;
         5'h0d: rate_of = `ACR_RATE_0D;
         5'h0e: rate_of = `ACR_RATE_0E;
         5'h0f: rate_of = `ACR_RATE_0F;
         default: rate_of = `ACR_RATE_SAT;
      endcase
   endfunction

   // filter field to effective filter, sinc5 forced at high rates
   function automatic logic [2:0] filter_of(input logic [4:0] code, input logic [2:0] fld);
      if (code >= `ACR_SINC5_MIN_CODE) begin
         filter_of = ACR_FLT_SINC5;
      end else begin
         case (fld)
            3'h0: filter_of = ACR_FLT_SINC1;
            3'h2: filter_of = ACR_FLT_SINC3;
            3'h3: filter_of = ACR_FLT_SINC4;
            3'h4: filter_of = ACR_FLT_FIR;
            default: filter_of = ACR_FLT_RSVD;
         endcase
      end
   endfunction

   // delay code to microseconds at the nominal clock
   function automatic logic [14:0] delay_of(input logic [3:0] code);
      case (code)
         4'h0: delay_of = `ACR_DLY_0;
         4'h1: delay_of = `ACR_DLY_1;
         4'h2: delay_of = `ACR_DLY_2;
         4'h3: delay_of = `ACR_DLY_3;
         4'h4: delay_of = `ACR_DLY_4;
         4'h5: delay_of = `ACR_DLY_5;
         4'h6: delay_of = `ACR_DLY_6;
         4'h7: delay_of = `ACR_DLY_7;
         4'h8: delay_of = `ACR_DLY_8;
         4'h9: delay_of = `ACR_DLY_9;
         4'ha: delay_of = `ACR_DLY_A;
         4'hb: delay_of = `ACR_DLY_B;
         4'hc: delay_of = `ACR_DLY_C;
         default: delay_of = `ACR_DLY_D;
      endcase
   endfunction

   // register writes, all bits stored as written
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rate_filter_ff <= `ACR_RST_RATE_FILTER; // RL1 RL3 RL5
         conv_ctrl_ff <= `ACR_RST_CONV_CTRL; // RL8 RL9 RL11
         rsv_byte_ff <= `ACR_RST_RSV_BYTE; // RL14
      end else if (wr_en_in) begin
         case (addr_in)
            `ACR_ADDR_RATE_FILTER: rate_filter_ff <= wr_data_in; // RL1
            `ACR_ADDR_CONV_CTRL: conv_ctrl_ff <= wr_data_in; // RL8
            `ACR_ADDR_RSV_BYTE: rsv_byte_ff <= wr_data_in; // RL14
            default: ;
         endcase
      end
   end

   // read data one cycle after the strobe, unmapped reads give zero
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rd_data_ff <= 8'h00;
      end else if (rd_en_in) begin
         case (addr_in)
            `ACR_ADDR_RATE_FILTER: rd_data_ff <= rate_filter_ff; // RL1
            `ACR_ADDR_CONV_CTRL: rd_data_ff <= conv_ctrl_ff;
            `ACR_ADDR_RSV_BYTE: rd_data_ff <= rsv_byte_ff; // RL14
            default: rd_data_ff <= 8'h00;
         endcase
      end else begin
         rd_data_ff <= 8'h00;
      end
   end
   assign rd_data_out = rd_data_ff;

   // run level history for one-shot edge detection
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         run_d_ff <= 1'b0;
      end else begin
         run_d_ff <= run_in;
      end
   end

   // continuous restarts while run is high, one-shot needs a rising edge
   assign start_req = (state_ff == ACR_IDLE) &&
      (conv_ctrl_ff[`ACR_MODE_BIT] ? (run_in && !run_d_ff) : run_in); // RL9

   // delay in ticks, scaled down for the faster external clock
   always_comb begin
      logic [31:0] us;
      us = 32'(delay_of(conv_ctrl_ff[3:0])); // RL11 RL12 RL13
      if (ext_clk_in) begin
         us = (us * `ACR_EXT_SCALE_NUM) / `ACR_EXT_SCALE_DEN; // RL10
      end
      nxt_delay = us[14:0];
   end

   // microsecond tick divider, restarted for every delay
   always_ff @(posedge clock_in) begin
      if (rst_in || state_ff != ACR_DELAY || tick) begin
         tick_div_ff <= 16'h0000;
      end else begin
         tick_div_ff <= tick_div_ff + 16'h0001;
      end
   end
   assign tick = (state_ff == ACR_DELAY) && (tick_div_ff == 16'(DELAY_TICK_CYCLES - 1));

   // ticks elapsed in the delay state
   always_ff @(posedge clock_in) begin
      if (rst_in || state_ff != ACR_DELAY) begin
         tick_cnt_ff <= 15'h0000;
      end else if (tick) begin
         tick_cnt_ff <= tick_cnt_ff + 15'h0001;
      end
   end

   // next sequencer state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ACR_IDLE: begin
            if (start_req) begin
               nxt_state = (nxt_delay == 15'h0000) ? ACR_CONV : ACR_DELAY; // RL11
            end
         end
         ACR_DELAY: begin
            if (tick && tick_cnt_ff == act_delay_ff - 15'h0001) begin
               nxt_state = ACR_CONV; // RL10
            end
         end
         ACR_CONV: begin
            if (conv_done_in) begin
               nxt_state = ACR_IDLE;
            end
         end
         default: nxt_state = ACR_IDLE;
      endcase
   end

   // sequencer state and conversion start pulse
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_ff <= ACR_IDLE;
         conv_start_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         conv_start_ff <= (nxt_state == ACR_CONV) && (state_ff != ACR_CONV);
      end
   end

   // settings captured only when a start is taken, ahead of the start delay
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         act_rate_ff <= 5'(`ACR_RST_RATE_FILTER >> 3);
         act_filter_ff <= ACR_FLT_FIR;
         act_mode_ff <= 1'b0;
         act_delay_ff <= `ACR_DLY_1;
      end else if (start_req) begin
         act_rate_ff <= rate_filter_ff[7:3]; // RL15
         act_filter_ff <= filter_of(rate_filter_ff[7:3], rate_filter_ff[2:0]); // RL6 RL5
         act_mode_ff <= conv_ctrl_ff[`ACR_MODE_BIT]; // RL15
         act_delay_ff <= nxt_delay; // RL15
      end
   end

   // outputs toward the engine
   assign conv_start_out = conv_start_ff;
   assign conv_busy_out = (state_ff == ACR_CONV);
   assign delay_busy_out = (state_ff == ACR_DELAY);
   assign act_rate_code_out = act_rate_ff;
   assign act_rate_dsps_out = rate_of(act_rate_ff); // RL2 RL4
   assign act_filter_out = act_filter_ff;
   assign act_mode_out = act_mode_ff;

   // cycles spent in the delay state, for the timing check
   logic [31:0] dly_cyc_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in || state_ff != ACR_DELAY) begin
         dly_cyc_ff <= 32'h0;
      end else begin
         dly_cyc_ff <= dly_cyc_ff + 32'h1;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   // reset values land one cycle after reset
   property p_reset_vals;
      @(posedge clock_in) disable iff (1'b0)
      rst_in |=> (rate_filter_ff == `ACR_RST_RATE_FILTER &&
         conv_ctrl_ff == `ACR_RST_CONV_CTRL && rsv_byte_ff == `ACR_RST_RSV_BYTE);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // RL1

   // register read returns the stored byte in the next cycle
   property p_read_rf;
      (rd_en_in && addr_in == `ACR_ADDR_RATE_FILTER && !wr_en_in) |=>
         (rd_data_out == $past(rate_filter_ff));
   endproperty
   a_read_rf: assert property (p_read_rf) else $error("rate/filter readback wrong"); // RL1

   // saturating and lowest rate codes
   property p_rate_ends;
      ((act_rate_code_out >= `ACR_SAT_MIN_CODE) |-> (act_rate_dsps_out == `ACR_RATE_SAT)) and
      ((act_rate_code_out == 5'h00) |-> (act_rate_dsps_out == `ACR_RATE_00));
   endproperty
   a_rate_ends: assert property (p_rate_ends) else $error("rate end code wrong"); // RL2

   // rates rise with code below saturation
   property p_rate_mono;
      (act_rate_code_out inside {[5'h01:5'h0f]}) |->
         (act_rate_dsps_out > rate_of(act_rate_code_out - 5'h01) &&
          (act_rate_code_out != 5'h0f || act_rate_dsps_out == 19'd256000));
   endproperty
   a_rate_mono: assert property (p_rate_mono) else $error("rate not ascending"); // RL4

   // sinc5 forced at and above 14.4 kSPS
   property p_sinc5;
      (act_rate_dsps_out >= 19'd144000) |-> (act_filter_out == ACR_FLT_SINC5);
   endproperty
   a_sinc5: assert property (p_sinc5) else $error("sinc5 not forced"); // RL6

   // FIR filter field mapping taken at start
   property p_filter_map;
      (start_req && rate_filter_ff[7:3] < `ACR_SINC5_MIN_CODE && rate_filter_ff[2:0] == 3'h4)
         |=> (act_filter_out == ACR_FLT_FIR);
   endproperty
   a_filter_map: assert property (p_filter_map) else $error("filter map wrong"); // RL5

   // continuous mode restarts right after a conversion ends
   sequence s_conv_end_cont;
      conv_busy_out && conv_done_in && !conv_ctrl_ff[4] && run_in;
   endsequence
   property p_cont_restart;
      s_conv_end_cont ##1 (conv_ctrl_ff[4] == 1'b0 && run_in) |-> !conv_busy_out ##1 !(state_ff == ACR_IDLE);
   endproperty
   a_cont_restart: assert property (p_cont_restart) else $error("no continuous restart"); // RL9

   // one-shot waits idle while run stays high
   property p_oneshot_hold;
      (state_ff == ACR_IDLE && act_mode_ff && conv_ctrl_ff[4] && run_in && run_d_ff)
         |=> (state_ff == ACR_IDLE);
   endproperty
   a_oneshot_hold: assert property (p_oneshot_hold) else $error("one-shot restarted"); // RL9

   // delay state lasts exactly the latched ticks
   property p_delay_len;
      (state_ff == ACR_DELAY && nxt_state == ACR_CONV)
         |-> (dly_cyc_ff + 32'h1 == 32'(act_delay_ff) * DELAY_TICK_CYCLES);
   endproperty
   a_delay_len: assert property (p_delay_len) else $error("start delay length wrong"); // RL10

   // code zero goes straight to converting
   sequence s_zero_start;
      start_req && conv_ctrl_ff[3:0] == 4'h0;
   endsequence
   property p_zero_delay;
      s_zero_start |=> conv_busy_out && conv_start_out;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay not skipped"); // RL11

   // default code gives 50 us at the nominal clock
   property p_default_delay;
      (start_req && conv_ctrl_ff[3:0] == 4'h1 && !ext_clk_in) |=> (act_delay_ff == 15'd50);
   endproperty
   a_default_delay: assert property (p_default_delay) else $error("default delay wrong"); // RL11

   // long codes at the nominal clock
   property p_long_delay;
      (start_req && !ext_clk_in && conv_ctrl_ff[3:0] == 4'h8) |=> (act_delay_ff == 15'd605);
   endproperty
   a_long_delay: assert property (p_long_delay) else $error("605 us code wrong"); // RL12

   property p_max_delay;
      (start_req && !ext_clk_in && conv_ctrl_ff[3:0] == 4'hd) |=> (act_delay_ff == 15'd17800);
   endproperty
   a_max_delay: assert property (p_max_delay) else $error("17.8 ms code wrong"); // RL13

   // reserved byte keeps what was written
   property p_rsv_byte;
      (wr_en_in && addr_in == `ACR_ADDR_RSV_BYTE) |=> (rsv_byte_ff == $past(wr_data_in));
   endproperty
   a_rsv_byte: assert property (p_rsv_byte) else $error("reserved byte not stored"); // RL14

   // settings hold steady through a conversion
   property p_stable_conv;
      (conv_busy_out && $past(conv_busy_out)) |->
         ($stable(act_rate_code_out) && $stable(act_filter_out) && $stable(act_mode_out));
   endproperty
   a_stable_conv: assert property (p_stable_conv) else $error("settings changed mid-conversion"); // RL15

endmodule // acr_mode_regs
`default_nettype wire

// ### design/acr_defines.svh
/*
 Constants of the rate, filter and conversion-control register group.
 Assumes a 50 MHz system clock and an 8-bit register port.
*/
// Contract
// RL1: Register 02h resets to 24h and holds the rate select in bits 7:3 and filter select in 2:0.
// RL2: Rate code 00000 converts at 2.5 SPS and codes 10000 to 11111 all convert at 40 kSPS.
// RL3: After reset the rate select holds 4h, which is 20 SPS.
// RL4: Rate codes between the lowest and the saturating range rise in rate up to 25.6 kSPS.
// RL5: Filter select 000 is sinc1, 010 sinc3, 011 sinc4, 100 FIR (default), others reserved.
// RL6: At output rates of 14.4 kSPS and above the sinc5 filter is used whatever the field says.
// RL7: Software pairs the FIR filter only with 2.5, 5, 10 or 20 SPS.
// RL8: Register 03h resets to 01h and software writes zeros to its bits 7:5.
// RL9: Bit 4 of register 03h selects continuous (0, default) or one-shot (1) conversion.
// RL10: Bits 3:0 of register 03h set the start delay, shorter with the faster external clock.
// RL11: Delay code 0000 gives no delay and code 0001, the default, gives 50 us.
// RL12: Delay codes 0010, 0011, 0100 give 59, 67, 85 us and code 1000 gives 605 us.
// RL13: Delay code 1001 gives 2.27 ms, 1101 gives 17.8 ms, and 1110 or 1111 are not written.
// RL14: Register 04h is a read/write byte that resets to 00h and software leaves at zero.
// RL15: Setting changes take effect at the next conversion start, never mid-conversion.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_ADDR_RATE_FILTER 8'h02
`define ACR_ADDR_CONV_CTRL 8'h03
`define ACR_ADDR_RSV_BYTE 8'h04
`define ACR_RST_RATE_FILTER 8'h24
`define ACR_RST_CONV_CTRL 8'h01
`define ACR_RST_RSV_BYTE 8'h00
`define ACR_MODE_BIT 4
`define ACR_SINC5_MIN_CODE 5'h0d
`define ACR_SAT_MIN_CODE 5'h10
`define ACR_CLK_PERIOD_NS 20
`define ACR_US_NS 1000
`define ACR_US_CYCLES (`ACR_US_NS / `ACR_CLK_PERIOD_NS)
`define ACR_EXT_SCALE_NUM 18
`define ACR_EXT_SCALE_DEN 25
// output rates in tenths of a sample per second
`define ACR_RATE_00 19'd25
`define ACR_RATE_01 19'd50
`define ACR_RATE_02 19'd100
`define ACR_RATE_03 19'd166
`define ACR_RATE_04 19'd200
`define ACR_RATE_05 19'd500
`define ACR_RATE_06 19'd600
`define ACR_RATE_07 19'd1000
`define ACR_RATE_08 19'd4000
`define ACR_RATE_09 19'd12000
`define ACR_RATE_0A 19'd24000
`define ACR_RATE_0B 19'd48000
`define ACR_RATE_0C 19'd72000
`define ACR_RATE_0D 19'd144000
`define ACR_RATE_0E 19'd192000
`define ACR_RATE_0F 19'd256000
`define ACR_RATE_SAT 19'd400000
// start delays in microseconds at the nominal clock
`define ACR_DLY_0 15'd0
`define ACR_DLY_1 15'd50
`define ACR_DLY_2 15'd59
`define ACR_DLY_3 15'd67
`define ACR_DLY_4 15'd85
`define ACR_DLY_5 15'd106
`define ACR_DLY_6 15'd132
`define ACR_DLY_7 15'd328
`define ACR_DLY_8 15'd605
`define ACR_DLY_9 15'd2270
`define ACR_DLY_A 15'd4500
`define ACR_DLY_B 15'd9000
`define ACR_DLY_C 15'd13400
`define ACR_DLY_D 15'd17800
`endif

// ### design/acr_pkg.sv
/*
 Types of the rate, filter and conversion-control register group.
 Assumes acr_defines.svh supplies the numeric constants.
*/
package acr_pkg;
   // effective filter handed to the conversion engine
   typedef enum logic [2:0] {
      ACR_FLT_SINC1 = 3'h0,
      ACR_FLT_RSVD = 3'h1,
      ACR_FLT_SINC3 = 3'h2,
      ACR_FLT_SINC4 = 3'h3,
      ACR_FLT_FIR = 3'h4,
      ACR_FLT_SINC5 = 3'h5
   } acr_filter_t;
   // sequencer states, gray along idle, delay, convert
   typedef enum logic [1:0] {
      ACR_IDLE = 2'h0,
      ACR_DELAY = 2'h1,
      ACR_CONV = 2'h3
   } acr_state_t;
endpackage

// ### sim/acr_eng_model.sv
/*
 Behavioural conversion engine facing the register group.
 Assumes the same clock as the block; ends each conversion lat_in + 1 cycles after its start pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_eng_model (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // latency from the bench, start from the block
   input wire logic [7:0] lat_in,
   input wire logic conv_start_in,
   // end of conversion toward the block
   output logic conv_done_out
);
   logic [7:0] cnt_ff;
   // count down from each start, one-cycle done pulse at the end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         cnt_ff <= 8'h00;
         conv_done_out <= 1'b0;
      end else begin
         conv_done_out <= (cnt_ff == 8'h01);
         if (conv_start_in) begin
            cnt_ff <= lat_in;
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule // acr_eng_model
`default_nettype wire

// ### sim/adc_mode_config_registers_tb.sv
/*
 Self-checking bench of the rate, filter and conversion-control registers.
 Assumes acr_eng_model stands in for the conversion engine on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_mode_config_registers_tb;
   localparam int TICK = 2;
   // one register access case: address, write data, expected read
   typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} acr_row_t;
   logic clock_in, rst_in, wr_en, rd_en, run, ext_clk, conv_done;
   logic [7:0] addr, wr_data, rd_data, lat;
   logic conv_start, conv_busy, delay_busy, act_mode;
   logic [4:0] act_code;
   logic [18:0] act_dsps;
   logic [2:0] act_filter;
   int err_count, samples_checked, start_cnt;
   int rate_tbl[17] = '{25, 50, 100, 166, 200, 500, 600, 1000, 4000, 12000, 24000, 48000,
      72000, 144000, 192000, 256000, 400000};
   int dly_tbl[14] = '{0, 50, 59, 67, 85, 106, 132, 328, 605, 2270, 4500, 9000, 13400, 17800};
   logic [2:0] flt_tbl[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h1, 3'h1};
   acr_row_t rows[8] = '{'{8'h02, 8'ha3, 8'ha3}, '{8'h03, 8'h1d, 8'h1d}, '{8'h04, 8'ha5, 8'ha5},
      '{8'h04, 8'h00, 8'h00}, '{8'h05, 8'h77, 8'h00}, '{8'h00, 8'hff, 8'h00},
      '{8'hff, 8'hff, 8'h00}, '{8'h02, 8'h24, 8'h24}};

   acr_mode_regs #(.DELAY_TICK_CYCLES(TICK)) dut (.clock_in(clock_in), .rst_in(rst_in),
      .addr_in(addr), .wr_data_in(wr_data), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .rd_data_out(rd_data), .run_in(run), .ext_clk_in(ext_clk), .conv_done_in(conv_done),
      .conv_start_out(conv_start), .conv_busy_out(conv_busy), .delay_busy_out(delay_busy),
      .act_rate_code_out(act_code), .act_rate_dsps_out(act_dsps),
      .act_filter_out(act_filter), .act_mode_out(act_mode));
   acr_eng_model eng (.clock_in(clock_in), .rst_in(rst_in), .lat_in(lat),
      .conv_start_in(conv_start), .conv_done_out(conv_done));

   // 50 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // count conversion starts
   always @(posedge clock_in) begin
      if (conv_start === 1'b1) start_cnt++;
   end
   // hang guard
   initial begin
      repeat (90000) @(posedge clock_in);
      err_count++;
      tally_and_finish();
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one-cycle write, then a spare edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock_in);
      wr_en <= 1'b0;
      @(posedge clock_in);
   endtask
   // one-cycle read; data only in the next cycle, 00 after
   task automatic rd_check(input logic [7:0] a, input logic [7:0] e, input string name);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock_in);
      rd_en <= 1'b0;
      #1 check(name, rd_data, e);
      @(posedge clock_in);
      #1 check("rd_idle", rd_data, 8'h00);
      @(posedge clock_in);
   endtask
   // bounded wait until the conversion ends, back on an edge
   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (conv_busy !== 1'b0 && n < 1000) begin
         @(posedge clock_in);
         #1 n++;
      end
      check("busy_end", conv_busy, 1'b0);
      @(posedge clock_in);
   endtask
   // start one conversion, compare edges from take to start pulse
   task automatic conv(input int exp);
      int n;
      n = 0;
      run <= 1'b1;
      @(posedge clock_in);
      #1;
      check("delay_busy", delay_busy, exp != 0);
      while (conv_start !== 1'b1 && n < 40000) begin
         @(posedge clock_in);
         #1 n++;
      end
      check("start_delay", n, exp);
      @(posedge clock_in);
      run <= 1'b0;
      wait_idle();
   endtask

   initial begin
      logic [2:0] f;
      int n0;
      rst_in = 1'b1;
      addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      run = 1'b0;
      ext_clk = 1'b0;
      lat = 8'h01;
      err_count = 0;
      samples_checked = 0;
      start_cnt = 0;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      #1 check("rst_code", act_code, 5'h04);
      check("rst_dsps", act_dsps, 19'd200);
      check("rst_filter", act_filter, 3'h4);
      check("rst_mode", act_mode, 1'b0);
      @(posedge clock_in);
      rd_check(8'h02, 8'h24, "rst_02");
      rd_check(8'h03, 8'h01, "rst_03");
      rd_check(8'h04, 8'h00, "rst_04");
      // ordinary register cases, unmapped places included
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd_check(rows[i].a, rows[i].e, "reg_rw");
      end
      // every rate code, filter forced at the high rates
      wr(8'h03, 8'h01);
      for (int c = 0; c < 32; c++) begin
         f = (c <= 4 && c != 3) ? 3'h4 : 3'h2;
         wr(8'h02, {c[4:0], f});
         conv(TICK * 50);
         check("rate_code", act_code, c[4:0]);
         check("rate_dsps", act_dsps, rate_tbl[(c > 16) ? 16 : c]);
         check("rate_filter", act_filter, (c >= 13) ? 3'h5 : f);
      end
      // every filter code at 20 SPS, no start delay
      wr(8'h03, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(8'h02, {5'h04, k[2:0]});
         conv(0);
         check("filter", act_filter, flt_tbl[k]);
      end
      // start delays at the nominal clock
      wr(8'h02, 8'h24);
      for (int k = 0; k < 14; k++) begin
         if (k >= 10 && k < 13) continue;
         wr(8'h03, {4'h0, k[3:0]});
         conv(dly_tbl[k] * TICK);
      end
      // faster external clock shortens the delay
      ext_clk <= 1'b1;
      wr(8'h03, 8'h01);
      conv(36 * TICK);
      wr(8'h03, 8'h09);
      conv(1634 * TICK);
      ext_clk <= 1'b0;
      // one-shot: one conversion per rising run edge
      wr(8'h03, 8'h10);
      n0 = start_cnt;
      run <= 1'b1;
      repeat (60) @(posedge clock_in);
      #1 check("oneshot_starts", start_cnt - n0, 1);
      check("oneshot_mode", act_mode, 1'b1);
      @(posedge clock_in);
      run <= 1'b0;
      @(posedge clock_in);
      run <= 1'b1;
      repeat (60) @(posedge clock_in);
      #1 check("oneshot_again", start_cnt - n0, 2);
      @(posedge clock_in);
      run <= 1'b0;
      // continuous: repeats while run stays high
      wr(8'h03, 8'h00);
      n0 = start_cnt;
      run <= 1'b1;
      repeat (60) @(posedge clock_in);
      run <= 1'b0;
      wait_idle();
      check("cont_repeat", start_cnt > n0 + 3, 1'b1);
      // settings written mid-conversion wait for the next start
      lat <= 8'd40;
      wr(8'h03, 8'h01);
      run <= 1'b1;
      repeat (110) @(posedge clock_in);
      run <= 1'b0;
      wr(8'h02, 8'h3a);
      #1 check("mid_busy", conv_busy, 1'b1);
      check("mid_code", act_code, 5'h04);
      check("mid_filter", act_filter, 3'h4);
      wait_idle();
      conv(TICK * 50);
      check("next_code", act_code, 5'h07);
      check("next_filter", act_filter, 3'h2);
      // reset in the middle of a long start delay
      wr(8'h03, 8'h09);
      run <= 1'b1;
      repeat (20) @(posedge clock_in);
      rst_in <= 1'b1;
      run <= 1'b0;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      #1 check("rst_delay", delay_busy, 1'b0);
      check("rst2_code", act_code, 5'h04);
      @(posedge clock_in);
      rd_check(8'h02, 8'h24, "rst2_02");
      rd_check(8'h03, 8'h01, "rst2_03");
      tally_and_finish();
   end
endmodule // adc_mode_config_registers_tb
`default_nettype wire
